// [include/bccx_pkg.sv]
// Package of constants and types for the chain crossbar extension block.
package bccx_pkg;

  // --------------------------------------------------------------------
  // Register offsets and reset value
  // --------------------------------------------------------------------
  localparam logic [7:0] BCCX_OFS_MAP_HOST = 8'h4C;
  localparam logic [7:0] BCCX_OFS_MAP_LINK = 8'h6C;
  localparam logic [7:0] BCCX_MAP_RESET = 8'h00;

  // --------------------------------------------------------------------
  // Field positions of the crossbar map register
  // --------------------------------------------------------------------
  localparam int BCCX_FSI_LSB = 0;
  localparam int BCCX_FSI_MSB = 2;
  localparam int BCCX_CLK_BIT = 3;
  localparam int BCCX_IRQ_BIT = 4;
  localparam int BCCX_MAO_BIT = 5;
  localparam int BCCX_PREV_BIT = 6;
  localparam int BCCX_NEXT_BIT = 7;

  // --------------------------------------------------------------------
  // Pin eligibility per function, bit 0 is the first I/O pin
  // --------------------------------------------------------------------
  localparam logic [5:0] BCCX_ELIG_CLK = 6'h3D;
  localparam logic [5:0] BCCX_ELIG_IRQ = 6'h3F;
  localparam logic [5:0] BCCX_ELIG_MAO = 6'h3E;
  localparam logic [5:0] BCCX_ELIG_PREV = 6'h3C;
  localparam logic [5:0] BCCX_ELIG_BK = 6'h38;
  localparam logic [5:0] BCCX_ELIG_NEXT_OUT = 6'h30;
  localparam logic [5:0] BCCX_ELIG_NEXT_IN = 6'h20;

  // --------------------------------------------------------------------
  // Pins taken by the fast sensor interface per mapping code
  // --------------------------------------------------------------------
  localparam logic [5:0] BCCX_FSI_NONE = 6'h00;
  localparam logic [5:0] BCCX_FSI_TWO = 6'h03;
  localparam logic [5:0] BCCX_FSI_THREE = 6'h07;
  localparam logic [5:0] BCCX_FSI_FOUR = 6'h0F;

  // --------------------------------------------------------------------
  // Data RAM for the previous slave's stream
  // --------------------------------------------------------------------
  localparam int BCCX_RAM_BYTES = 64;
  localparam int BCCX_RAM_AW = 6;
  localparam int BCCX_BIT_CNT_W = 10;
  localparam logic [9:0] BCCX_BIT_CNT_ZERO = 10'h000;

  typedef enum logic [1:0] {
    BCCX_BUF_PASS = 2'b00,
    BCCX_BUF_FILL = 2'b01,
    BCCX_BUF_DRAIN = 2'b10
  } bccx_buf_e;

endpackage : bccx_pkg

// [rtl/bccx_prev_buf.sv]
// Data RAM buffer for the bit stream of the previous slave.
`timescale 1ns/1ps
`default_nettype none

module bccx_prev_buf
  import bccx_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Fill side.
  input wire logic fill_i,
  input wire logic bit_stb_i,
  input wire logic bit_i,
  // Drain side.
  input wire logic pop_i,
  output logic bit_o,
  output logic empty_o,
  output logic overflow_o
);

  logic [7:0] mem [0:BCCX_RAM_BYTES-1];
  bccx_buf_e state_r;
  bccx_buf_e state_nxt;
  logic [BCCX_BIT_CNT_W-1:0] wbit_r;
  logic [BCCX_BIT_CNT_W-1:0] rbit_r;
  logic [7:0] byte_r;
  logic ovf_r;

  wire logic full = wbit_r[BCCX_BIT_CNT_W-1];
  wire logic store = (state_r == BCCX_BUF_FILL) && bit_stb_i && !full;
  wire logic [2:0] widx = wbit_r[2:0];
  wire logic [BCCX_RAM_AW-1:0] waddr = wbit_r[8:3];
  wire logic [BCCX_RAM_AW-1:0] raddr = rbit_r[8:3];
  wire logic [2:0] rsel = 3'd7 - rbit_r[2:0];
  wire logic [7:0] byte_base = (widx == 3'd0) ? 8'h00 : byte_r;
  wire logic [7:0] byte_new = byte_base | (8'h80 >> widx);
  wire logic [7:0] byte_wr = bit_i ? byte_new : byte_base;
  wire logic last_pop = pop_i && (rbit_r + 10'd1 == wbit_r);

  assign bit_o = mem[raddr][rsel];
  assign empty_o = (state_r != BCCX_BUF_DRAIN);
  assign overflow_o = ovf_r;

  // Bytes are kept left aligned so a partial last byte drains in order.
  always_ff @(posedge clock_i) begin
    if (store) begin
      mem[waddr] <= byte_wr;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BCCX_BUF_PASS: begin
        if (fill_i) begin
          state_nxt = BCCX_BUF_FILL;
        end
      end
      BCCX_BUF_FILL: begin
        if (!fill_i) begin
          state_nxt = (wbit_r == BCCX_BIT_CNT_ZERO) ? BCCX_BUF_PASS
                                                    : BCCX_BUF_DRAIN;
        end
      end
      BCCX_BUF_DRAIN: begin
        if (last_pop) begin
          state_nxt = BCCX_BUF_PASS;
        end
      end
      default: begin
        state_nxt = BCCX_BUF_PASS;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= BCCX_BUF_PASS;
      wbit_r <= BCCX_BIT_CNT_ZERO;
      rbit_r <= BCCX_BIT_CNT_ZERO;
      byte_r <= 8'h00;
      ovf_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (store) begin
        byte_r <= byte_wr;
        wbit_r <= wbit_r + 10'd1;
      end else if (state_nxt == BCCX_BUF_PASS) begin
        wbit_r <= BCCX_BIT_CNT_ZERO;
      end
      if (state_r == BCCX_BUF_DRAIN && pop_i && !last_pop) begin
        rbit_r <= rbit_r + 10'd1;
      end else if (state_nxt == BCCX_BUF_PASS) begin
        rbit_r <= BCCX_BIT_CNT_ZERO;
      end
      // A bit lost to a full RAM wins over the clear at a new fill.
      if (state_r == BCCX_BUF_FILL && bit_stb_i && full) begin
        ovf_r <= 1'b1;
      end else if (state_r == BCCX_BUF_PASS && fill_i) begin
        ovf_r <= 1'b0;
      end
    end
  end

endmodule : bccx_prev_buf
`default_nettype wire

// [rtl/bccx_chain_xbar.sv]
// Crossbar mapping and daisy chain data paths of the slave bridge.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Previous slave input takes next free pin.
// - Coupler control mapped only when enabled.
// - Command 2 toggles the coupler control level.
// - Chain disabled links chain out to in.
// - Chain enabled maps both chain pins when pins 4 and 5 are still free.
// - Own slave data drives chain output.
// - Returned chain stream drives line output.
// - Buffer previous slave data during host transfer.
// - Unmapped previous input reads as zero.
// - Pins allocated by descending function priority.

module bccx_chain_xbar
  import bccx_pkg::*;
(
  // System clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Link clock domain.
  input wire logic field_clock_in_i,
  input wire logic link_wr_i,
  input wire logic [7:0] link_addr_i,
  input wire logic [7:0] link_wdata_i,
  input wire logic link_cmd2_i,
  // Host register port.
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  // Slave core interface.
  input wire logic coupler_cmd_en_i,
  input wire logic own_data_i,
  input wire logic host_sdad_busy_i,
  input wire logic prev_bit_stb_i,
  input wire logic prev_pop_i,
  output logic prev_data_o,
  output logic prev_buf_empty_o,
  output logic prev_buf_ovf_o,
  // Field line and coupler.
  output logic field_data_out_o,
  output logic bus_coupler_ctl_o,
  // Crossbar I/O pins.
  input wire logic [5:0] io_i,
  output logic [5:0] io_o,
  output logic [5:0] io_oe_o
);

  // ------------------------------------------------------------------
  // Allocation helpers
  // ------------------------------------------------------------------
  // Returns the lowest eligible pin not yet taken, or none.
  function automatic logic [5:0] pick_pin(input logic [5:0] used,
                                          input logic [5:0] elig,
                                          input logic en);
    logic [5:0] free;
    logic [5:0] hit;
    free = elig & ~used;
    hit = 6'h00;
    for (int i = 5; i >= 0; i--) begin
      if (en && free[i]) begin
        hit = 6'h01 << i;
      end
    end
    return hit;
  endfunction : pick_pin

  function automatic logic [5:0] fsi_pins(input logic [2:0] code);
    logic [5:0] pins;
    case (code)
      3'd1: pins = BCCX_FSI_THREE;
      3'd2: pins = BCCX_FSI_TWO;
      3'd3: pins = BCCX_FSI_TWO;
      3'd5: pins = BCCX_FSI_FOUR;
      3'd6: pins = BCCX_FSI_THREE;
      3'd7: pins = BCCX_FSI_THREE;
      default: pins = BCCX_FSI_NONE;
    endcase
    return pins;
  endfunction : fsi_pins

  // Flags a new toggle level once the second and third stages agree.
  function automatic logic tog_event(input logic s2, input logic s3,
                                     input logic seen);
    return (s2 == s3) && (s3 != seen);
  endfunction : tog_event

  // ------------------------------------------------------------------
  // Link clock domain
  // ------------------------------------------------------------------
  logic lk_wr_tog_r;
  logic [7:0] lk_data_r;
  logic lk_cmd_tog_r;

  wire logic lk_map_wr = link_wr_i && (link_addr_i == BCCX_OFS_MAP_LINK);

  // Data is held stable until the next link write, so it can be read
  // in the system domain after the toggle has crossed.
  always_ff @(posedge field_clock_in_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lk_wr_tog_r <= 1'b0;
      lk_data_r <= BCCX_MAP_RESET;
      lk_cmd_tog_r <= 1'b0;
    end else begin
      if (lk_map_wr) begin
        lk_data_r <= link_wdata_i;
        lk_wr_tog_r <= ~lk_wr_tog_r;
      end
      if (link_cmd2_i) begin
        lk_cmd_tog_r <= ~lk_cmd_tog_r;
      end
    end
  end

  // ------------------------------------------------------------------
  // Crossings into the system domain
  // ------------------------------------------------------------------
  logic [2:0] wr_sync_r;
  logic [2:0] cmd_sync_r;
  logic wr_seen_r;
  logic cmd_seen_r;
  logic [5:0] io_s1_r;
  logic [5:0] io_s2_r;
  logic [5:0] io_s3_r;
  logic [5:0] io_filt_r;

  wire logic lk_wr_ev = tog_event(wr_sync_r[1], wr_sync_r[2], wr_seen_r);
  wire logic cmd2_ev = tog_event(cmd_sync_r[1], cmd_sync_r[2], cmd_seen_r);
  wire logic [5:0] io_agree = ~(io_s2_r ^ io_s3_r);
  wire logic [5:0] io_filt_nxt = (io_agree & io_s3_r) |
                                 (~io_agree & io_filt_r);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_sync_r <= 3'h0;
      cmd_sync_r <= 3'h0;
      wr_seen_r <= 1'b0;
      cmd_seen_r <= 1'b0;
      io_s1_r <= 6'h00;
      io_s2_r <= 6'h00;
      io_s3_r <= 6'h00;
      io_filt_r <= 6'h00;
    end else begin
      wr_sync_r <= {wr_sync_r[1:0], lk_wr_tog_r};
      cmd_sync_r <= {cmd_sync_r[1:0], lk_cmd_tog_r};
      if (lk_wr_ev) begin
        wr_seen_r <= wr_sync_r[2];
      end
      if (cmd2_ev) begin
        cmd_seen_r <= cmd_sync_r[2];
      end
      io_s1_r <= io_i;
      io_s2_r <= io_s1_r;
      io_s3_r <= io_s2_r;
      io_filt_r <= io_filt_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Crossbar map register
  // ------------------------------------------------------------------
  logic [7:0] map_r;
  logic [7:0] rdata_r;
  logic bk_r;

  wire logic host_map_wr = host_wr_i && (host_addr_i == BCCX_OFS_MAP_HOST);
  wire logic host_map_rd = host_rd_i && (host_addr_i == BCCX_OFS_MAP_HOST);

  // A host write in the same cycle as a crossed link write wins.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      map_r <= BCCX_MAP_RESET;
      rdata_r <= 8'h00;
      bk_r <= 1'b0;
    end else begin
      if (host_map_wr) begin
        map_r <= host_wdata_i;
      end else if (lk_wr_ev) begin
        map_r <= lk_data_r;
      end
      if (host_rd_i) begin
        rdata_r <= host_map_rd ? map_r : 8'h00;
      end
      if (cmd2_ev) begin
        bk_r <= ~bk_r;
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin allocation in descending priority
  // ------------------------------------------------------------------
  wire logic next_en = map_r[BCCX_NEXT_BIT];
  wire logic prev_en = map_r[BCCX_PREV_BIT];
  wire logic [5:0] used0 = fsi_pins(map_r[BCCX_FSI_MSB:BCCX_FSI_LSB]);
  wire logic [5:0] p_clk = pick_pin(used0, BCCX_ELIG_CLK,
                                    map_r[BCCX_CLK_BIT]);
  wire logic [5:0] used1 = used0 | p_clk;
  wire logic [5:0] p_irq = pick_pin(used1, BCCX_ELIG_IRQ,
                                    map_r[BCCX_IRQ_BIT]);
  wire logic [5:0] used2 = used1 | p_irq;
  wire logic [5:0] p_mao = pick_pin(used2, BCCX_ELIG_MAO,
                                    map_r[BCCX_MAO_BIT]);
  wire logic [5:0] used3 = used2 | p_mao;
  wire logic [5:0] p_prev = pick_pin(used3, BCCX_ELIG_PREV, prev_en);
  wire logic [5:0] used4 = used3 | p_prev;
  wire logic [5:0] p_bk = pick_pin(used4, BCCX_ELIG_BK,
                                   coupler_cmd_en_i);
  wire logic [5:0] used5 = used4 | p_bk;
  wire logic [5:0] p_nout = pick_pin(used5, BCCX_ELIG_NEXT_OUT,
                                     next_en);
  wire logic [5:0] used6 = used5 | p_nout;
  wire logic [5:0] p_nin = pick_pin(used6, BCCX_ELIG_NEXT_IN,
                                    next_en);

  logic [5:0] pin_prev_r;
  logic [5:0] pin_bk_r;
  logic [5:0] pin_nout_r;
  logic [5:0] pin_nin_r;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_prev_r <= 6'h00;
      pin_bk_r <= 6'h00;
      pin_nout_r <= 6'h00;
      pin_nin_r <= 6'h00;
    end else begin
      pin_prev_r <= p_prev;
      pin_bk_r <= p_bk;
      pin_nout_r <= p_nout;
      pin_nin_r <= p_nin;
    end
  end

  // ------------------------------------------------------------------
  // Chain data paths
  // ------------------------------------------------------------------
  wire logic prev_in = |(io_filt_r & pin_prev_r);
  wire logic chain_mapped = |pin_nin_r;
  wire logic next_in = |(io_filt_r & pin_nin_r);
  // Without a return pin the chain is closed inside, own data only.
  wire logic line_nxt = chain_mapped ? next_in
                                     : own_data_i;
  wire logic [5:0] io_o_nxt = (pin_bk_r & {6{bk_r}}) |
                              (pin_nout_r & {6{own_data_i}});
  wire logic [5:0] io_oe_nxt = pin_bk_r | pin_nout_r;
  wire logic buf_bit;
  wire logic buf_empty;
  wire logic buf_ovf;
  wire logic prev_nxt = buf_empty ? prev_in : buf_bit;

  bccx_prev_buf u_prev_buf (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .fill_i(host_sdad_busy_i),
    .bit_stb_i(prev_bit_stb_i),
    .bit_i(prev_in),
    .pop_i(prev_pop_i),
    .bit_o(buf_bit),
    .empty_o(buf_empty),
    .overflow_o(buf_ovf)
  );

  // ------------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------------
  logic line_r;
  logic bk_out_r;
  logic prev_r;
  logic prev_empty_r;
  logic prev_ovf_r;
  logic [5:0] io_o_r;
  logic [5:0] io_oe_r;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      line_r <= 1'b0;
      bk_out_r <= 1'b0;
      prev_r <= 1'b0;
      prev_empty_r <= 1'b1;
      prev_ovf_r <= 1'b0;
      io_o_r <= 6'h00;
      io_oe_r <= 6'h00;
    end else begin
      line_r <= line_nxt;
      bk_out_r <= bk_r;
      prev_r <= prev_nxt;
      prev_empty_r <= buf_empty;
      prev_ovf_r <= buf_ovf;
      io_o_r <= io_o_nxt;
      io_oe_r <= io_oe_nxt;
    end
  end

  assign host_rdata_o = rdata_r;
  assign field_data_out_o = line_r;
  assign bus_coupler_ctl_o = bk_out_r;
  assign prev_data_o = prev_r;
  assign prev_buf_empty_o = prev_empty_r;
  assign prev_buf_ovf_o = prev_ovf_r;
  assign io_o = io_o_r;
  assign io_oe_o = io_oe_r;

endmodule : bccx_chain_xbar
`default_nettype wire

// [sim/bccx_chain_xbar_properties.sv]
// Concurrent checks on the ports of the chain crossbar extension block.
`timescale 1ns/1ps
`default_nettype none

module bccx_chain_xbar_properties (
  // Clocks and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic field_clock_in_i,
  // Host port and core side.
  input wire logic host_rd_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic coupler_cmd_en_i,
  input wire logic own_data_i,
  input wire logic host_sdad_busy_i,
  input wire logic prev_buf_empty_o,
  // Line, coupler and pins.
  input wire logic field_data_out_o,
  input wire logic bus_coupler_ctl_o,
  input wire logic [5:0] io_i,
  input wire logic [5:0] io_o,
  input wire logic [5:0] io_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // Counts system cycles since the link clock last rose, saturating.
  logic lk_q_r;
  logic [3:0] since_r;
  logic [3:0] since_nxt;
  assign since_nxt = (field_clock_in_i && !lk_q_r) ? 4'h0 :
                     (since_r == 4'hF) ? since_r : since_r + 4'h1;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lk_q_r <= 1'b1;
      since_r <= 4'hF;
    end else begin
      lk_q_r <= field_clock_in_i;
      since_r <= since_nxt;
    end
  end

  reset_idle_a: assert property ($fell(sys_rst_i) |->
    io_oe_o == 6'h00 && prev_buf_empty_o) else $error("outputs after reset");
  low_pins_a: assert property (io_oe_o[2:0] == 3'b000)
    else $error("driver on first three pins");
  coupler_pin_a: assert property (io_oe_o[3] |->
    io_o[3] == bus_coupler_ctl_o) else $error("coupler pin level");
  coupler_off_a: assert property ((!coupler_cmd_en_i)[*4] |->
    !io_oe_o[3]) else $error("coupler placed while disabled");
  toggle_cause_a: assert property ($changed(bus_coupler_ctl_o) |->
    since_r < 4'h9) else $error("coupler toggled without link");
  own_line_a: assert property ((io_oe_o == 6'h00)[*3] |->
    field_data_out_o == $past(own_data_i)) else $error("line not own data");
  own_chain_a: assert property ((!coupler_cmd_en_i &&
    io_oe_o == 6'h10)[*2] |-> io_o[4] == $past(own_data_i))
    else $error("chain out not own data");
  chain_return_a: assert property ((!coupler_cmd_en_i &&
    io_oe_o == 6'h10)[*6] |-> field_data_out_o == $past(io_i[5], 5))
    else $error("line not chain return");
  read_unmapped_a: assert property (host_rd_i && host_addr_i != 8'h4C
    |=> host_rdata_o == 8'h00) else $error("unmapped read not zero");
  drain_start_a: assert property ($fell(prev_buf_empty_o) |->
    !host_sdad_busy_i && ($past(host_sdad_busy_i) ||
    $past(host_sdad_busy_i, 2) || $past(host_sdad_busy_i, 3)))
    else $error("drain without end of fill");
endmodule : bccx_chain_xbar_properties

bind bccx_chain_xbar bccx_chain_xbar_properties i_bccx_chain_xbar_properties (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .field_clock_in_i(field_clock_in_i), .host_rd_i(host_rd_i),
  .host_addr_i(host_addr_i), .host_rdata_o(host_rdata_o),
  .coupler_cmd_en_i(coupler_cmd_en_i), .own_data_i(own_data_i),
  .host_sdad_busy_i(host_sdad_busy_i), .prev_buf_empty_o(prev_buf_empty_o),
  .field_data_out_o(field_data_out_o), .bus_coupler_ctl_o(bus_coupler_ctl_o),
  .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o));

`default_nettype wire

// [sim/bccx_link_master.sv]
// Link master model sending register writes and commands in short frames.
`timescale 1ns/1ps
`default_nettype none

module bccx_link_master (
  // Link clock and decoded frame content.
  output logic field_clock_in_o,
  output logic link_wr_o,
  output logic [7:0] link_addr_o,
  output logic [7:0] link_wdata_o,
  output logic link_cmd2_o
);
  initial begin
    field_clock_in_o = 1'b1;
    link_wr_o = 1'b0;
    link_cmd2_o = 1'b0;
    link_addr_o = 8'h00;
    link_wdata_o = 8'h00;
  end

  // The clock idles high and only runs inside a frame.
  // Frames reach only the crossbar map, so length, CRC and ring settings
  // keep their legal defaults.
  task automatic frame(input logic wr, input logic cmd2,
                       input logic [7:0] a, input logic [7:0] d);
    #37;
    link_wr_o = wr;
    link_cmd2_o = cmd2;
    link_addr_o = a;
    link_wdata_o = d;
    field_clock_in_o = 1'b0;
    #62.5 field_clock_in_o = 1'b1;
    #62.5 field_clock_in_o = 1'b0;
    link_wr_o = 1'b0;
    link_cmd2_o = 1'b0;
    link_addr_o = ~a;
    link_wdata_o = ~d;
    #62.5 field_clock_in_o = 1'b1;
    #1000;
  endtask : frame
endmodule : bccx_link_master

`default_nettype wire

// [sim/bccx_chain_xbar_test.sv]
// Testbench of the chain crossbar extension block.
`timescale 1ns/1ps
`default_nettype none

module bccx_chain_xbar_test
  import bccx_pkg::*;
;
  logic clock_i, sys_rst_i, host_wr_i, host_rd_i, coupler_cmd_en_i;
  logic own_data_i, host_sdad_busy_i, prev_bit_stb_i, prev_pop_i;
  logic [7:0] host_addr_i, host_wdata_i, host_rdata_o;
  logic [5:0] io_i, io_o, io_oe_o;
  logic prev_data_o, prev_buf_empty_o, field_data_out_o, bus_coupler_ctl_o;
  logic prev_buf_ovf_o;
  logic lk_clk, lk_wr, lk_cmd2;
  logic [7:0] lk_addr, lk_wdata;
  int error_cnt = 0;
  int n_checks = 0;

  bccx_link_master i_bccx_link_master (.field_clock_in_o(lk_clk),
    .link_wr_o(lk_wr), .link_addr_o(lk_addr), .link_wdata_o(lk_wdata),
    .link_cmd2_o(lk_cmd2));

  bccx_chain_xbar i_bccx_chain_xbar (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .field_clock_in_i(lk_clk), .link_wr_i(lk_wr), .link_addr_i(lk_addr),
    .link_wdata_i(lk_wdata), .link_cmd2_i(lk_cmd2), .host_wr_i(host_wr_i),
    .host_rd_i(host_rd_i), .host_addr_i(host_addr_i),
    .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
    .coupler_cmd_en_i(coupler_cmd_en_i), .own_data_i(own_data_i),
    .host_sdad_busy_i(host_sdad_busy_i), .prev_bit_stb_i(prev_bit_stb_i),
    .prev_pop_i(prev_pop_i), .prev_data_o(prev_data_o),
    .prev_buf_empty_o(prev_buf_empty_o), .prev_buf_ovf_o(prev_buf_ovf_o),
    .field_data_out_o(field_data_out_o),
    .bus_coupler_ctl_o(bus_coupler_ctl_o),
    .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o));

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc

  task automatic chk_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: bit %b, expected %b", $time, g, e);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: byte %h, expected %h", $time, g, e);
    end
  endtask : chk_byte

  task automatic host_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    host_wr_i <= 1'b1;
    host_addr_i <= a;
    host_wdata_i <= d;
    @(posedge clock_i);
    host_wr_i <= 1'b0;
  endtask : host_write

  task automatic host_read(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    host_rd_i <= 1'b1;
    host_addr_i <= a;
    @(posedge clock_i);
    host_rd_i <= 1'b0;
    cyc(1);
    chk_byte(host_rdata_o, e);
  endtask : host_read

  task automatic t_reset;
    host_write(8'h4D, 8'hFF);
    host_read(BCCX_OFS_MAP_HOST, BCCX_MAP_RESET);
    host_read(8'h10, 8'h00);
    chk_byte({2'b00, io_oe_o}, 8'h00);
    chk_bit(prev_buf_empty_o, 1'b1);
  endtask : t_reset

  task automatic t_prev;
    int pin [8] = '{2, 3, 2, 2, 2, 4, 3, 3};
    for (int c = 0; c < 8; c++) begin
      host_write(BCCX_OFS_MAP_HOST, 8'h40 | 8'(c));
      io_i <= 6'h01 << pin[c];
      cyc(8);
      chk_bit(prev_data_o, 1'b1);
      @(posedge clock_i);
      io_i <= ~(6'h01 << pin[c]);
      cyc(8);
      chk_bit(prev_data_o, 1'b0);
    end
    host_write(BCCX_OFS_MAP_HOST, 8'h00);
    io_i <= 6'h3F;
    cyc(8);
    chk_bit(prev_data_o, 1'b0);
  endtask : t_prev

  task automatic t_chain;
    host_write(BCCX_OFS_MAP_HOST, 8'h80);
    for (int v = 0; v < 2; v++) begin
      @(posedge clock_i);
      own_data_i <= v[0];
      io_i <= {~v[0], 5'h00};
      cyc(8);
      chk_byte({2'b00, io_oe_o}, 8'h10);
      chk_bit(io_o[4], v[0]);
      chk_bit(field_data_out_o, ~v[0]);
    end
    host_read(BCCX_OFS_MAP_HOST, 8'h80);
    host_write(BCCX_OFS_MAP_HOST, 8'h00);
    cyc(8);
    chk_byte({2'b00, io_oe_o}, 8'h00);
    chk_bit(field_data_out_o, 1'b1);
  endtask : t_chain

  task automatic t_coupler;
    @(posedge clock_i);
    coupler_cmd_en_i <= 1'b1;
    host_write(BCCX_OFS_MAP_HOST, 8'hC0);
    cyc(8);
    chk_byte({2'b00, io_oe_o}, 8'h18);
    @(posedge clock_i);
    coupler_cmd_en_i <= 1'b0;
    cyc(8);
    chk_byte({2'b00, io_oe_o}, 8'h10);
    host_write(BCCX_OFS_MAP_HOST, 8'hF8);
    io_i <= 6'h08;
    cyc(8);
    chk_bit(prev_data_o, 1'b1);
    chk_byte({2'b00, io_oe_o}, 8'h10);
    @(posedge clock_i);
    coupler_cmd_en_i <= 1'b1;
    cyc(8);
    chk_byte({2'b00, io_oe_o}, 8'h30);
    chk_bit(field_data_out_o, 1'b1);
  endtask : t_coupler

  task automatic t_cmd2;
    logic b;
    @(posedge clock_i);
    coupler_cmd_en_i <= 1'b1;
    host_write(BCCX_OFS_MAP_HOST, 8'h00);
    for (int k = 0; k < 2; k++) begin
      b = bus_coupler_ctl_o;
      i_bccx_link_master.frame(1'b0, 1'b1, 8'h00, 8'h00);
      cyc(2);
      chk_bit(bus_coupler_ctl_o, ~b);
      chk_bit(io_o[3], ~b);
    end
    chk_byte({2'b00, io_oe_o}, 8'h08);
  endtask : t_cmd2

  task automatic t_link;
    i_bccx_link_master.frame(1'b1, 1'b0, BCCX_OFS_MAP_LINK, 8'h80);
    i_bccx_link_master.frame(1'b1, 1'b0, 8'h6D, 8'h00);
    host_read(BCCX_OFS_MAP_HOST, 8'h80);
    host_write(BCCX_OFS_MAP_HOST, 8'h40);
  endtask : t_link

  task automatic t_buf;
    logic [3:0] pat;
    pat = 4'b1101;
    host_sdad_busy_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      io_i <= {3'b000, pat[i], 2'b00};
      cyc(6);
      @(posedge clock_i);
      prev_bit_stb_i <= 1'b1;
      @(posedge clock_i);
      prev_bit_stb_i <= 1'b0;
    end
    host_sdad_busy_i <= 1'b0;
    io_i <= 6'h00;
    cyc(3);
    chk_bit(prev_buf_empty_o, 1'b0);
    for (int i = 0; i < 4; i++) begin
      chk_bit(prev_data_o, pat[i]);
      @(posedge clock_i);
      prev_pop_i <= 1'b1;
      @(posedge clock_i);
      prev_pop_i <= 1'b0;
      cyc(2);
    end
    chk_bit(prev_buf_empty_o, 1'b1);
    chk_bit(prev_buf_ovf_o, 1'b0);
    @(posedge clock_i);
    host_sdad_busy_i <= 1'b1;
    prev_bit_stb_i <= 1'b1;
    repeat (520) @(posedge clock_i);
    prev_bit_stb_i <= 1'b0;
    host_sdad_busy_i <= 1'b0;
    prev_pop_i <= 1'b1;
    cyc(3);
    chk_bit(prev_buf_ovf_o, 1'b1);
    chk_bit(prev_buf_empty_o, 1'b0);
    @(posedge clock_i);
    repeat (520) @(posedge clock_i);
    prev_pop_i <= 1'b0;
    host_sdad_busy_i <= 1'b1;
    cyc(3);
    chk_bit(prev_buf_empty_o, 1'b1);
    chk_bit(prev_buf_ovf_o, 1'b0);
  endtask : t_buf

  task automatic report_and_stop;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    sys_rst_i = 1'b1;
    {host_wr_i, host_rd_i, coupler_cmd_en_i, own_data_i} = 4'h0;
    {host_sdad_busy_i, prev_bit_stb_i, prev_pop_i} = 3'b000;
    host_addr_i = 8'h00;
    host_wdata_i = 8'h00;
    io_i = 6'h00;
    cyc(20);
    @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_prev;
    t_chain;
    t_coupler;
    t_cmd2;
    t_link;
    t_buf;
    report_and_stop;
  end

  initial begin
    #400000;
    error_cnt++;
    report_and_stop;
  end
endmodule : bccx_chain_xbar_test

`default_nettype wire
